/* File: mcusk_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the ALU/skip/table unit
// Assumes: Included by its bare name wherever the constants are needed
// Notes:   Definitions only
`ifndef MCUSK_CFG_SVH
`define MCUSK_CFG_SVH

// ===========================================
// Register offsets (byte addresses, 8-bit bus)
`define MCUSK_OFS_WREG      8'h00
`define MCUSK_OFS_STATUS    8'h01
`define MCUSK_OFS_PTR_LO    8'h02
`define MCUSK_OFS_PTR_HI    8'h03
`define MCUSK_OFS_HIGH_BYTE 8'h04
`define MCUSK_OFS_MEM_BASE  8'h40

// ===========================================
// Status field positions
`define MCUSK_FLAG_C  0
`define MCUSK_FLAG_AC 1
`define MCUSK_FLAG_Z  2
`define MCUSK_FLAG_OV 3

// ===========================================
// Reset values and constants
`define MCUSK_RST_BYTE  8'h00
`define MCUSK_ALL_ONES  8'hff
`define MCUSK_DEC_STEP  8'h01
`define MCUSK_DUMMY_CYC 1

`endif

/* File: mcusk_pkg.sv */
// Purpose: Types shared by the ALU/skip/table unit
// Assumes: Constants live in mcusk_cfg.svh
// Notes:   Opcode enum is the command set of the instruction port
`default_nettype none
package mcusk_pkg;

    // ===========================================
    // Operations
    typedef enum logic [4:0] {
        OP_NOP                      = 5'h00,
        OP_MINUS_WREG               = 5'h01,
        OP_MINUS_IMM                = 5'h02,
        OP_MINUS_TO_MEM             = 5'h03,
        OP_MINUS_WITH_BORROW_TO_WREG = 5'h04,
        OP_MINUS_WITH_BORROW_TO_MEM = 5'h05,
        OP_DEC_SKIP_NULL            = 5'h06,
        OP_DEC_SKIP_NULL_WREG       = 5'h07,
        OP_INC_SKIP_NULL            = 5'h08,
        OP_INC_SKIP_NULL_WREG       = 5'h09,
        OP_SKIP_ON_NULL             = 5'h0a,
        OP_COPY_SKIP_ON_NULL        = 5'h0b,
        OP_SKIP_BIT_NULL            = 5'h0c,
        OP_SKIP_BIT_NONNULL         = 5'h0d,
        OP_SET_BYTE                 = 5'h0e,
        OP_SET_BIT                  = 5'h0f,
        OP_NIBBLE_EXCHANGE          = 5'h10,
        OP_NIBBLE_EXCHANGE_WREG     = 5'h11,
        OP_EXCLUSIVE_OR_WREG        = 5'h12,
        OP_EXCLUSIVE_OR_TO_MEM      = 5'h13,
        OP_EXCLUSIVE_OR_IMM         = 5'h14,
        OP_PROG_LOOKUP_GIVEN_PAGE   = 5'h15,
        OP_PROG_LOOKUP_CURRENT_PAGE = 5'h16,
        OP_PROG_LOOKUP_FINAL_PAGE   = 5'h17
    } mcusk_op_e;

    // ===========================================
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TABLE = 3'b010,
        ST_DUMMY = 3'b100
    } mcusk_state_e;

    // ===========================================
    // Instruction port carrier
    typedef struct packed {
        logic valid;
        mcusk_op_e op;
        logic [7:0] addr;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } mcusk_instr_s;

    // Register bus request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcusk_bus_s;

    // Subtractor result
    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic ac;
        logic ov;
        logic z;
    } mcusk_sub_s;

endpackage : mcusk_pkg
`default_nettype wire

/* File: mcusk_core.sv */
// Purpose: Execution unit for subtract, skip, set, swap, XOR and program-table reads
// Assumes: One instruction offered at a time, only while ready_o is high
// Notes:   Data memory held in flops; program memory answers while prog_req_o is high
`timescale 1ns/10ps
`default_nettype none
`include "mcusk_cfg.svh"

// Behaviour
// - Subtraction carry clear on negative, set otherwise
// - Subtracts update exactly OV, Z, AC, C
// - Borrow-to-memory: wreg minus mem minus borrow
// - Plain subtract: wreg minus mem into wreg
// - Subtract to memory leaves wreg unchanged
// - Immediate subtract result into wreg
// - Taken skip inserts one dummy cycle
// - Decrement memory, write back, skip on zero
// - Decrement into wreg, memory kept, skip zero
// - Increment memory, write back, skip on zero
// - Increment into wreg, memory kept, skip zero
// - Skip when byte zero, nothing modified
// - Copy byte to wreg, skip on zero
// - Bit tests skip on zero or nonzero
// - Byte set writes all ones, flags kept
// - Bit set forces one bit, flags kept
// - Nibble swap to memory or wreg, no flags
// - XOR variants update only zero flag
// - Given-page lookup uses both pointer bytes
// - Current-page lookup uses page and low pointer
// - Final-page lookup uses last page, low pointer
module mcusk_core #(
    parameter int DEPTH = 64,
    parameter int PW = 16
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Register bus
    input wire mcusk_pkg::mcusk_bus_s bus_i,
    output logic [7:0] rdata_o,
    // Instruction port
    input wire mcusk_pkg::mcusk_instr_s instr_i,
    input wire logic [PW-9:0] cur_page_i,
    output logic ready_o,
    output logic done_o,
    output logic skipped_o,
    output logic dummy_o,
    // Program memory
    output logic prog_req_o,
    output logic [PW-1:0] prog_addr_o,
    input wire logic [15:0] prog_data_i,
    // Visible state
    output logic [7:0] wreg_o,
    output logic [7:0] status_o
);
    import mcusk_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // ===========================================
    // Reset release
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ===========================================
    // State
    mcusk_state_e state;
    logic [7:0] wreg;
    logic c_flag, ac_flag, z_flag, ov_flag;
    logic [7:0] ptr_lo, ptr_hi, high_byte;
    logic [7:0] dmem [DEPTH];
    logic skip_pend;
    logic [AW-1:0] tab_idx;

    function automatic mcusk_sub_s mcusk_sub(input logic [7:0] a, input logic [7:0] b, input logic brw);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b} - {8'h00, brw};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, brw};
        mcusk_sub.res = full[7:0];
        mcusk_sub.c = ~full[8];
        mcusk_sub.ac = ~low[4];
        mcusk_sub.ov = (a[7] ^ b[7]) & (a[7] ^ full[7]);
        mcusk_sub.z = (full[7:0] == `MCUSK_RST_BYTE);
    endfunction : mcusk_sub

    function automatic logic mcusk_is_mem(input logic [7:0] a);
        mcusk_is_mem = ({1'b0, a} >= {1'b0, `MCUSK_OFS_MEM_BASE})
            && ({1'b0, a} < ({1'b0, `MCUSK_OFS_MEM_BASE} + 9'(DEPTH)));
    endfunction : mcusk_is_mem

    // ===========================================
    // Decode and datapath
    logic accept;
    logic discard;
    logic [AW-1:0] op_idx;
    logic [7:0] opnd;
    logic [7:0] sel_mask;
    mcusk_sub_s sub_r;
    logic next_wreg_we, next_mem_we, next_sub_we, next_z_we, next_z;
    logic [7:0] next_wreg, next_mem;
    logic next_skip, next_table;
    logic [PW-1:0] next_prog_addr;

    assign accept = ce_i && instr_i.valid && (state == ST_IDLE);
    assign discard = accept && skip_pend;
    assign op_idx = instr_i.addr[AW-1:0];
    assign opnd = dmem[op_idx];
    assign sel_mask = 8'h01 << instr_i.bit_sel;

    always_comb begin
        logic [7:0] b;
        logic brw;
        b = (instr_i.op == OP_MINUS_IMM) ? instr_i.imm : opnd;
        brw = (instr_i.op == OP_MINUS_WITH_BORROW_TO_WREG || instr_i.op == OP_MINUS_WITH_BORROW_TO_MEM) & ~c_flag;
        sub_r = mcusk_sub(wreg, b, brw);
        next_wreg_we = 1'b0;
        next_mem_we = 1'b0;
        next_sub_we = 1'b0;
        next_z_we = 1'b0;
        next_z = 1'b0;
        next_wreg = wreg;
        next_mem = opnd;
        next_skip = 1'b0;
        next_table = 1'b0;
        next_prog_addr = {ptr_hi[PW-9:0], ptr_lo};
        case (instr_i.op)
            OP_MINUS_WREG, OP_MINUS_IMM, OP_MINUS_WITH_BORROW_TO_WREG: begin
                next_wreg = sub_r.res;
                next_wreg_we = 1'b1;
                next_sub_we = 1'b1;
            end
            OP_MINUS_TO_MEM, OP_MINUS_WITH_BORROW_TO_MEM: begin
                next_mem = sub_r.res;
                next_mem_we = 1'b1;
                next_sub_we = 1'b1;
            end
            OP_DEC_SKIP_NULL, OP_INC_SKIP_NULL: begin
                next_mem = (instr_i.op == OP_DEC_SKIP_NULL) ? opnd - `MCUSK_DEC_STEP : opnd + `MCUSK_DEC_STEP;
                next_mem_we = 1'b1;
                next_skip = (next_mem == `MCUSK_RST_BYTE);
            end
            OP_DEC_SKIP_NULL_WREG, OP_INC_SKIP_NULL_WREG: begin
                next_wreg = (instr_i.op == OP_DEC_SKIP_NULL_WREG) ? opnd - `MCUSK_DEC_STEP
                    : opnd + `MCUSK_DEC_STEP;
                next_wreg_we = 1'b1;
                next_skip = (next_wreg == `MCUSK_RST_BYTE);
            end
            OP_SKIP_ON_NULL: next_skip = (opnd == `MCUSK_RST_BYTE);
            OP_COPY_SKIP_ON_NULL: begin
                next_wreg = opnd;
                next_wreg_we = 1'b1;
                next_skip = (opnd == `MCUSK_RST_BYTE);
            end
            OP_SKIP_BIT_NULL: next_skip = ~|(opnd & sel_mask);
            OP_SKIP_BIT_NONNULL: next_skip = |(opnd & sel_mask);
            OP_SET_BYTE: begin
                next_mem = `MCUSK_ALL_ONES;
                next_mem_we = 1'b1;
            end
            OP_SET_BIT: begin
                next_mem = opnd | sel_mask;
                next_mem_we = 1'b1;
            end
            OP_NIBBLE_EXCHANGE: begin
                next_mem = {opnd[3:0], opnd[7:4]};
                next_mem_we = 1'b1;
            end
            OP_NIBBLE_EXCHANGE_WREG: begin
                next_wreg = {opnd[3:0], opnd[7:4]};
                next_wreg_we = 1'b1;
            end
            OP_EXCLUSIVE_OR_WREG, OP_EXCLUSIVE_OR_IMM: begin
                next_wreg = wreg ^ ((instr_i.op == OP_EXCLUSIVE_OR_IMM) ? instr_i.imm : opnd);
                next_wreg_we = 1'b1;
                next_z_we = 1'b1;
                next_z = (next_wreg == `MCUSK_RST_BYTE);
            end
            OP_EXCLUSIVE_OR_TO_MEM: begin
                next_mem = wreg ^ opnd;
                next_mem_we = 1'b1;
                next_z_we = 1'b1;
                next_z = (next_mem == `MCUSK_RST_BYTE);
            end
            OP_PROG_LOOKUP_GIVEN_PAGE: next_table = 1'b1;
            OP_PROG_LOOKUP_CURRENT_PAGE: begin
                next_table = 1'b1;
                next_prog_addr = {cur_page_i, ptr_lo};
            end
            OP_PROG_LOOKUP_FINAL_PAGE: begin
                next_table = 1'b1;
                next_prog_addr = {{(PW-8){1'b1}}, ptr_lo};
            end
            default: next_wreg = wreg;
        endcase
    end

    logic do_exec;
    assign do_exec = accept && !skip_pend;

    // ===========================================
    // Sequencer
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            skip_pend <= 1'b0;
            tab_idx <= '0;
            prog_req_o <= 1'b0;
            prog_addr_o <= '0;
            dummy_o <= 1'b0;
        end else if (ce_i) begin
            prog_req_o <= 1'b0;
            dummy_o <= 1'b0;
            if (discard) begin
                skip_pend <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (do_exec && next_table) begin
                        state <= ST_TABLE;
                        tab_idx <= op_idx;
                        prog_req_o <= 1'b1;
                        prog_addr_o <= next_prog_addr;
                    end else if (do_exec && next_skip) begin
                        state <= ST_DUMMY;
                        skip_pend <= 1'b1;
                        dummy_o <= 1'b1;
                    end
                end
                ST_TABLE: state <= ST_IDLE;
                ST_DUMMY: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ===========================================
    // Working register and flags
    logic bus_wr_wreg, bus_wr_status;
    assign bus_wr_wreg = bus_i.wr && bus_i.addr == `MCUSK_OFS_WREG;
    assign bus_wr_status = bus_i.wr && bus_i.addr == `MCUSK_OFS_STATUS;

    // Execution beats a bus write landing in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wreg <= `MCUSK_RST_BYTE;
        end else if (ce_i) begin
            if (do_exec && next_wreg_we) begin
                wreg <= next_wreg;
            end else if (bus_wr_wreg) begin
                wreg <= bus_i.wdata;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            {ov_flag, z_flag, ac_flag, c_flag} <= 4'h0;
        end else if (ce_i) begin
            if (do_exec && next_sub_we) begin
                c_flag <= sub_r.c;
                ac_flag <= sub_r.ac;
                z_flag <= sub_r.z;
                ov_flag <= sub_r.ov;
            end else if (do_exec && next_z_we) begin
                z_flag <= next_z;
            end else if (bus_wr_status) begin
                c_flag <= bus_i.wdata[`MCUSK_FLAG_C];
                ac_flag <= bus_i.wdata[`MCUSK_FLAG_AC];
                z_flag <= bus_i.wdata[`MCUSK_FLAG_Z];
                ov_flag <= bus_i.wdata[`MCUSK_FLAG_OV];
            end
        end
    end

    // ===========================================
    // Table pointers and high byte
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ptr_lo <= `MCUSK_RST_BYTE;
            ptr_hi <= `MCUSK_RST_BYTE;
            high_byte <= `MCUSK_RST_BYTE;
        end else if (ce_i) begin
            if (bus_i.wr && bus_i.addr == `MCUSK_OFS_PTR_LO) ptr_lo <= bus_i.wdata;
            if (bus_i.wr && bus_i.addr == `MCUSK_OFS_PTR_HI) ptr_hi <= bus_i.wdata;
            if (state == ST_TABLE) high_byte <= prog_data_i[15:8];
        end
    end

    // ===========================================
    // Data memory; table write and execution beat the bus
    logic bus_mem;
    logic [AW-1:0] bus_idx;
    assign bus_mem = mcusk_is_mem(bus_i.addr);
    assign bus_idx = AW'(bus_i.addr - `MCUSK_OFS_MEM_BASE);

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_mem
            always_ff @(posedge core_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    dmem[gi] <= `MCUSK_RST_BYTE;
                end else if (ce_i) begin
                    if (state == ST_TABLE && tab_idx == AW'(gi)) begin
                        dmem[gi] <= prog_data_i[7:0];
                    end else if (do_exec && next_mem_we && op_idx == AW'(gi)) begin
                        dmem[gi] <= next_mem;
                    end else if (bus_i.wr && bus_mem && bus_idx == AW'(gi)) begin
                        dmem[gi] <= bus_i.wdata;
                    end
                end
            end
        end
    endgenerate

    // ===========================================
    // Handshake outputs and read data
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_o <= 1'b0;
            skipped_o <= 1'b0;
            ready_o <= 1'b0;
            rdata_o <= `MCUSK_RST_BYTE;
        end else if (ce_i) begin
            done_o <= (do_exec && !next_table && !next_skip) || (state != ST_IDLE);
            skipped_o <= discard;
            ready_o <= (state == ST_IDLE) ? !(do_exec && (next_table || next_skip)) : 1'b1;
            rdata_o <= `MCUSK_RST_BYTE;
            if (bus_i.rd) begin
                case (bus_i.addr)
                    `MCUSK_OFS_WREG: rdata_o <= wreg;
                    `MCUSK_OFS_STATUS: rdata_o <= {4'h0, ov_flag, z_flag, ac_flag, c_flag};
                    `MCUSK_OFS_PTR_LO: rdata_o <= ptr_lo;
                    `MCUSK_OFS_PTR_HI: rdata_o <= ptr_hi;
                    `MCUSK_OFS_HIGH_BYTE: rdata_o <= high_byte;
                    default: rdata_o <= bus_mem ? dmem[bus_idx] : `MCUSK_RST_BYTE;
                endcase
            end
        end
    end

    assign wreg_o = wreg;
    assign status_o = {4'h0, ov_flag, z_flag, ac_flag, c_flag};

    // ===========================================
    // Checks
    chk_carry_sign: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (do_exec && next_sub_we) |=> (c_flag == ($past(sub_r.res) < $past(wreg)) || $past(sub_r.res) == $past(wreg))
            && (c_flag == $past(sub_r.c)))
        else $error("carry not set from subtract");
    chk_sub_mem_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (do_exec && instr_i.op == OP_MINUS_TO_MEM && !bus_wr_wreg) |=> $stable(wreg))
        else $error("subtract to memory changed wreg");
    chk_skip_dummy: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (do_exec && next_skip && !next_table) |=> (state == ST_DUMMY) && dummy_o && !ready_o)
        else $error("taken skip did not insert dummy cycle");
    chk_dummy_len: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (state == ST_DUMMY && ce_i) |=> (state == ST_IDLE) && skip_pend)
        else $error("dummy cycle length wrong");
    chk_dec_mem: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (do_exec && instr_i.op == OP_DEC_SKIP_NULL && op_idx != tab_idx) |=>
            dmem[$past(op_idx)] == $past(opnd) - `MCUSK_DEC_STEP)
        else $error("decrement not written back");
    chk_skip_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (discard && !bus_i.wr) |=> $stable(wreg) && $stable(status_o) && skipped_o)
        else $error("skipped instruction had an effect");
    chk_xor_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (do_exec && next_z_we && !bus_wr_status) |=> $stable(c_flag) && $stable(ac_flag) && $stable(ov_flag))
        else $error("xor touched flags other than zero");
    chk_final_page: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (do_exec && instr_i.op == OP_PROG_LOOKUP_FINAL_PAGE) |=>
            prog_req_o && prog_addr_o == {{(PW-8){1'b1}}, $past(ptr_lo)} ##1 high_byte == $past(prog_data_i[15:8]))
        else $error("final page lookup wrong");

endmodule : mcusk_core
`default_nettype wire

/* File: tb_mcusk_core.sv */
// Purpose: Self-checking bench for the ALU/skip/table unit
// Assumes: Registers reached over the plain strobe bus; program memory modelled by a fixed code function
// Notes:   Each instruction issued by run is followed by a byte set on a spare location, to see skips consume it
`timescale 1ns/10ps
`default_nettype none
module tb_mcusk_core;
import mcusk_pkg::*;

logic core_clk_i = 1'b0;
logic arst_n_i = 1'b0;
logic ce_i = 1'b1;
mcusk_bus_s bus_i = '0;
mcusk_instr_s instr_i = '0;
logic [7:0] cur_page_i = 8'h00;
logic [15:0] prog_data_i;
logic [7:0] rdata_o;
logic [7:0] wreg_o;
logic [7:0] status_o;
logic ready_o;
logic done_o;
logic skipped_o;
logic dummy_o;
logic prog_req_o;
logic [15:0] prog_addr_o;
logic [15:0] last_addr = 16'h0000;
int mismatches = 0;
int num_checks = 0;
int cyc = 0;
int lat;
int dum;
logic skp;

// ===========================================
// Clock, program memory, timeout
always #5 core_clk_i = ~core_clk_i;

// Code word varies with every address bit, so a wrong page shows up
function automatic logic [15:0] code_at(input logic [15:0] a);
    return {a[7:0] ^ 8'h5a, a[15:8] ^ 8'hc3};
endfunction : code_at

assign prog_data_i = code_at(prog_addr_o);

always @(posedge core_clk_i) begin
    if (prog_req_o === 1'b1) begin
        last_addr <= prog_addr_o;
    end
end

always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
        mismatches++;
        final_report();
    end
end

mcusk_core #(.DEPTH(64), .PW(16)) dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .instr_i(instr_i), .cur_page_i(cur_page_i),
    .ready_o(ready_o), .done_o(done_o), .skipped_o(skipped_o), .dummy_o(dummy_o),
    .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
    .wreg_o(wreg_o), .status_o(status_o)
);

// ===========================================
// Tasks
task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask : final_report

task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
endtask : chk

task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus_i <= '0;
endtask : wr

task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    bus_i <= '0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, rdata_o}, {8'h00, e});
endtask : rd

// Operand x doubles as immediate and bit select
task automatic exec(input mcusk_op_e op, input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk_i);
    instr_i <= '{valid: 1'b1, op: op, addr: a, imm: x, bit_sel: x[2:0]};
    @(posedge core_clk_i);
    instr_i.valid <= 1'b0;
    dum = 0;
    skp = 1'b0;
    for (lat = 1; lat < 8; lat++) begin
        #1;
        if (dummy_o === 1'b1) dum++;
        if (skipped_o === 1'b1) skp = 1'b1;
        if (done_o === 1'b1 || skp) break;
        @(posedge core_clk_i);
    end
endtask : exec

task automatic run(input mcusk_op_e op, input logic [7:0] x, m, w, s, em, ew, es, input logic sk);
    wr(8'h40, m);
    wr(8'h00, w);
    wr(8'h01, s);
    wr(8'h41, 8'h00);
    exec(op, 8'h00, x);
    chk("latency", 16'(lat), sk ? 16'h0002 : 16'h0001);
    chk("dummy", 16'(dum), {15'h0000, sk});
    exec(OP_SET_BYTE, 8'h01, 8'h00);
    chk("skipped", {15'h0000, skp}, {15'h0000, sk});
    rd(8'h40, em);
    rd(8'h00, ew);
    rd(8'h01, es);
    chk("wreg out", {8'h00, wreg_o}, {8'h00, ew});
    chk("status out", {8'h00, status_o}, {8'h00, es});
    rd(8'h41, sk ? 8'h00 : 8'hff);
endtask : run

task automatic tab(input mcusk_op_e op, input logic [15:0] ea);
    logic [15:0] c;
    c = code_at(ea);
    wr(8'h40, 8'h00);
    exec(op, 8'h00, 8'h00);
    chk("table latency", 16'(lat), 16'h0002);
    chk("table address", last_addr, ea);
    rd(8'h40, c[7:0]);
    rd(8'h04, c[15:8]);
endtask : tab

// ===========================================
// Sequence
initial begin
    repeat (16) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    while (ready_o !== 1'b1) @(posedge core_clk_i);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    run(OP_MINUS_WREG, 8'h00, 8'h20, 8'h10, 8'h00, 8'h20, 8'hf0, 8'h02, 1'b0);
    run(OP_MINUS_IMM, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'h7f, 8'h09, 1'b0);
    run(OP_MINUS_TO_MEM, 8'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h05, 8'h07, 1'b0);
    run(OP_MINUS_WITH_BORROW_TO_MEM, 8'h00, 8'h03, 8'h05, 8'h00, 8'h01, 8'h05, 8'h03, 1'b0);
    run(OP_MINUS_WITH_BORROW_TO_WREG, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h07, 1'b0);
    run(OP_MINUS_WITH_BORROW_TO_WREG, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h00, 8'hff, 8'h00, 1'b0);
    run(OP_DEC_SKIP_NULL, 8'h00, 8'h01, 8'h33, 8'h0f, 8'h00, 8'h33, 8'h0f, 1'b1);
    run(OP_DEC_SKIP_NULL, 8'h00, 8'h00, 8'h33, 8'h0f, 8'hff, 8'h33, 8'h0f, 1'b0);
    run(OP_DEC_SKIP_NULL_WREG, 8'h00, 8'h01, 8'h33, 8'h00, 8'h01, 8'h00, 8'h00, 1'b1);
    run(OP_DEC_SKIP_NULL_WREG, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00, 8'hff, 8'h00, 1'b0);
    run(OP_INC_SKIP_NULL, 8'h00, 8'hff, 8'h33, 8'h0f, 8'h00, 8'h33, 8'h0f, 1'b1);
    run(OP_INC_SKIP_NULL, 8'h00, 8'h41, 8'h33, 8'h00, 8'h42, 8'h33, 8'h00, 1'b0);
    run(OP_INC_SKIP_NULL_WREG, 8'h00, 8'hff, 8'h33, 8'h00, 8'hff, 8'h00, 8'h00, 1'b1);
    run(OP_INC_SKIP_NULL_WREG, 8'h00, 8'h10, 8'h33, 8'h0f, 8'h10, 8'h11, 8'h0f, 1'b0);
    run(OP_SKIP_ON_NULL, 8'h00, 8'h00, 8'h33, 8'h0b, 8'h00, 8'h33, 8'h0b, 1'b1);
    run(OP_SKIP_ON_NULL, 8'h00, 8'h01, 8'h33, 8'h00, 8'h01, 8'h33, 8'h00, 1'b0);
    run(OP_COPY_SKIP_ON_NULL, 8'h00, 8'h00, 8'h33, 8'h0f, 8'h00, 8'h00, 8'h0f, 1'b1);
    run(OP_COPY_SKIP_ON_NULL, 8'h00, 8'h5a, 8'h33, 8'h00, 8'h5a, 8'h5a, 8'h00, 1'b0);
    run(OP_SKIP_BIT_NULL, 8'h03, 8'hf7, 8'h00, 8'h0f, 8'hf7, 8'h00, 8'h0f, 1'b1);
    run(OP_SKIP_BIT_NULL, 8'h03, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 1'b0);
    run(OP_SKIP_BIT_NONNULL, 8'h07, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 1'b1);
    run(OP_SKIP_BIT_NONNULL, 8'h03, 8'hf7, 8'h00, 8'h00, 8'hf7, 8'h00, 8'h00, 1'b0);
    run(OP_SET_BYTE, 8'h00, 8'h12, 8'h00, 8'h0f, 8'hff, 8'h00, 8'h0f, 1'b0);
    run(OP_SET_BIT, 8'h05, 8'h00, 8'h00, 8'h0f, 8'h20, 8'h00, 8'h0f, 1'b0);
    run(OP_SET_BIT, 8'h00, 8'hfe, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 1'b0);
    run(OP_NIBBLE_EXCHANGE, 8'h00, 8'h3c, 8'h00, 8'h0f, 8'hc3, 8'h00, 8'h0f, 1'b0);
    run(OP_NIBBLE_EXCHANGE_WREG, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h3c, 8'hc3, 8'h00, 1'b0);
    run(OP_EXCLUSIVE_OR_WREG, 8'h00, 8'h0f, 8'h0f, 8'h0b, 8'h0f, 8'h00, 8'h0f, 1'b0);
    run(OP_EXCLUSIVE_OR_TO_MEM, 8'h00, 8'hf0, 8'h0f, 8'h04, 8'hff, 8'h0f, 8'h00, 1'b0);
    run(OP_EXCLUSIVE_OR_IMM, 8'haa, 8'h00, 8'haa, 8'h0b, 8'h00, 8'h00, 8'h0f, 1'b0);
    wr(8'h02, 8'h34);
    wr(8'h03, 8'h12);
    @(posedge core_clk_i);
    cur_page_i <= 8'h56;
    tab(OP_PROG_LOOKUP_GIVEN_PAGE, 16'h1234);
    tab(OP_PROG_LOOKUP_CURRENT_PAGE, 16'h5634);
    tab(OP_PROG_LOOKUP_FINAL_PAGE, 16'hff34);
    wr(8'h04, 8'h77);
    rd(8'h04, 8'h6e);
    // Enable low must freeze a bus write
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    wr(8'h00, 8'h99);
    ce_i <= 1'b1;
    rd(8'h00, 8'h00);
    final_report();
end

endmodule : tb_mcusk_core
`default_nettype wire
